// *** irq_status.sv ***
// Purpose: sticky read-to-clear status, per-bit mask, open-drain request
// Assumes: event inputs synchronous to clk_i; read done is a pulse after data delivery
// Notes: bit OVERTEMP_BIT carries the die over-temperature event
// Operation
// - status bits latch on event, clear only by read once condition gone
// - read while condition persists leaves status bit set
// - status set on rising edge of the condition, not its level
// - one mask bit per status bit; set mask keeps bit off request
// - unmasked event sets status and asserts request
// - masked event sets status, request unchanged
// - request holds until every set unmasked bit has been read
// - reading a persisting unmasked bit drops request, status stays set
// - clearing mask of a set bit not yet read asserts request
// - request is open drain, driven low when asserted
// - die over-temperature is one of the notifying events
// - reset pin alone forces all state to defaults
// - no operation starts while reset is asserted
`timescale 1ns/100ps
module irq_status
    import irq_status_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // event conditions, level
    input wire logic [EVENT_COUNT-1:0] cond_i,
    // mask register value from the register file
    input wire logic [EVENT_COUNT-1:0] mask_wdata_i,
    input wire logic mask_we_i,
    // status read: pulse once data byte has been delivered
    input wire logic status_read_done_i,
    // register read-back
    output logic [EVENT_COUNT-1:0] status_o,
    output logic [EVENT_COUNT-1:0] mask_o,
    // open-drain interrupt request pin
    output logic int_n_o,
    output logic int_n_oe_o
);

    // ***********************
    // state and next values
    // ***********************
    // condition history for edge detect
    logic [EVENT_COUNT-1:0] cond_reg;
    logic [EVENT_COUNT-1:0] cond_next;

    // sticky status word
    logic [EVENT_COUNT-1:0] status_reg;
    logic [EVENT_COUNT-1:0] status_next;

    // mask word, one bit per status bit
    logic [EVENT_COUNT-1:0] mask_reg;
    logic [EVENT_COUNT-1:0] mask_next;

    // set and not yet read
    logic [EVENT_COUNT-1:0] pending_reg;
    logic [EVENT_COUNT-1:0] pending_next;

    // request enable of the open-drain pin
    logic int_oe_reg;
    logic int_oe_next;

    // one-cycle rising edges of the conditions
    logic [EVENT_COUNT-1:0] rise;

    // ***********************
    // functions
    // ***********************
    // rising edges of a level word against its history
    function automatic logic [EVENT_COUNT-1:0] edge_rise(
        input logic [EVENT_COUNT-1:0] level,
        input logic [EVENT_COUNT-1:0] prev
    );
        return level & ~prev;
    endfunction

    // sticky word: read keeps live bits, a new edge always wins
    function automatic logic [EVENT_COUNT-1:0] sticky_update(
        input logic [EVENT_COUNT-1:0] held,
        input logic [EVENT_COUNT-1:0] level,
        input logic [EVENT_COUNT-1:0] edges,
        input logic read
    );
        logic [EVENT_COUNT-1:0] kept;
        kept = read ? (held & level) : held;
        return kept | edges;
    endfunction

    // pending word: read drops every bit, a new edge always wins
    function automatic logic [EVENT_COUNT-1:0] pending_update(
        input logic [EVENT_COUNT-1:0] held,
        input logic [EVENT_COUNT-1:0] edges,
        input logic read
    );
        logic [EVENT_COUNT-1:0] kept;
        kept = read ? ZERO_WORD : held;
        return kept | edges;
    endfunction

    // request when any pending bit is not masked
    function automatic logic request_of(
        input logic [EVENT_COUNT-1:0] pend,
        input logic [EVENT_COUNT-1:0] masked
    );
        return |(pend & ~masked);
    endfunction

    // ***********************
    // edge detect
    // ***********************
    assign rise = edge_rise(cond_i, cond_reg);

    always_comb begin
        cond_next = cond_i;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cond_reg <= ZERO_WORD;
        end else begin
            cond_reg <= cond_next;
        end
    end

    // ***********************
    // sticky status
    // ***********************
    // set wins over clear; persisting conditions survive the read
    always_comb begin
        status_next = sticky_update(status_reg, cond_i, rise, status_read_done_i);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ***********************
    // mask
    // ***********************
    always_comb begin
        mask_next = mask_reg;
        if (mask_we_i) begin
            mask_next = mask_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mask_reg <= MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // ***********************
    // request tracking
    // ***********************
    // pending: set and not yet read; read drops it even if status stays
    always_comb begin
        pending_next = pending_update(pending_reg, rise, status_read_done_i);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pending_reg <= ZERO_WORD;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // request from pending bits under the current mask; unmask raises it
    always_comb begin
        int_oe_next = request_of(pending_reg, mask_reg);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            int_oe_reg <= 1'b0;
        end else begin
            int_oe_reg <= int_oe_next;
        end
    end

    // ***********************
    // open-drain pin
    // ***********************
    // pin level is always low; only the enable toggles
    always_ff @(posedge clk_i) begin
        int_n_o <= 1'b0;
    end

    always_comb begin
        int_n_oe_o = int_oe_reg;
    end

    // ***********************
    // read-back
    // ***********************
    always_comb begin
        status_o = status_reg;
        mask_o = mask_reg;
    end
endmodule

// *** irq_status_pkg.sv ***
// Purpose: shared constants for the sticky interrupt status block
// Assumes: one core clock, synchronous active-low reset
// Notes: event count is the width of the status and mask words
package irq_status_pkg;
    localparam int EVENT_COUNT = 8;
    localparam logic [EVENT_COUNT-1:0] STATUS_RESET = 8'h00;
    // all events masked out of the request after reset
    localparam logic [EVENT_COUNT-1:0] MASK_RESET = 8'hff;
    localparam logic [EVENT_COUNT-1:0] ZERO_WORD = 8'h00;
    localparam int OVERTEMP_BIT = 0;
endpackage

// *** irq_status_sva.sv ***
// Purpose: checker on irq_status ports
// Assumes: sync active-low reset
// Notes: prv mirrors the condition history
`timescale 1ns/100ps
module irq_status_sva
    import irq_status_pkg::*;
(
    input wire logic clk_i, nrst_i, mask_we_i, status_read_done_i, int_n_o, int_n_oe_o,
    input wire logic [EVENT_COUNT-1:0] cond_i, mask_wdata_i, status_o, mask_o
);
    logic [EVENT_COUNT-1:0] prv;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clk_i) prv <= nrst_i ? cond_i : '0;
    a_rise_sets_status: assert property ($past(nrst_i) |-> (status_o & $past(cond_i & ~prv)) == $past(cond_i & ~prv)) else $error("rise lost");
    a_status_stays_set: assert property (!status_read_done_i |=> (status_o & $past(status_o)) == $past(status_o)) else $error("status dropped");
    a_read_keeps_live: assert property (status_read_done_i |=> (status_o & $past(status_o & cond_i)) == $past(status_o & cond_i)) else $error("live bit cleared");
    a_read_clears_idle: assert property (status_read_done_i |=> (status_o & $past(status_o & ~cond_i)) == 8'h00) else $error("bit not cleared");
    a_all_masked_quiet: assert property (mask_o == 8'hff |=> !int_n_oe_o) else $error("masked request");
    a_irq_has_cause: assert property (int_n_oe_o |-> $past(|(status_o & ~mask_o))) else $error("request without cause");
    a_read_drops_irq: assert property (status_read_done_i && (cond_i & ~prv) == 8'h00 |=> ##1 !int_n_oe_o) else $error("request held");
    a_pin_drives_low: assert property (int_n_o == 1'b0) else $error("pin level");
    a_reset_defaults: assert property (disable iff (1'b0) !nrst_i |=> status_o == 8'h00 && mask_o == 8'hff && !int_n_oe_o) else $error("reset value");
    c_read_irq: cover property (status_read_done_i && int_n_oe_o);
    c_unmask_irq: cover property (mask_we_i && int_n_oe_o);
    c_read_live: cover property (status_read_done_i && |(status_o & cond_i));
endmodule
bind irq_status irq_status_sva irq_status_sva_inst(.*);

// *** proc_model.sv ***
// Purpose: processor reading status on request or by polling
// Assumes: read done is sampled every cycle; it stays high on back-to-back cycles while the request is seen
// Notes: reads start only 10 cycles after reset
`timescale 1ns/100ps
module proc_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic irq_i,
    output logic rd_o
);
    logic [3:0] quiet;
    initial rd_o = 1'b0;
    // no control access in the first 500 ns after reset
    always @(posedge clk_i) quiet <= !nrst_i ? 4'h0 : (quiet == 4'hc ? quiet : quiet + 4'h1);
    always @(posedge clk_i) rd_o <= #1 nrst_i && quiet >= 4'ha && (irq_i || $urandom % 8 == 0);
endmodule

// *** irq_status_tb_top.sv ***
// Purpose: random bench with reference model
// Assumes: 20 MHz clock
// Notes: compares every cycle
`timescale 1ns/100ps
module irq_status_tb_top;
    import irq_status_pkg::*;
    logic clk_i = 0, nrst_i = 0, mask_we_i = 0, rd, int_n_o, int_n_oe_o, oe;
    logic [7:0] cond_i = 0, mask_wdata_i = 0, status_o, mask_o, st, mk, pd, pv;
    int err_total = 0, n_tests = 0;
    always #25 clk_i = ~clk_i;
    irq_status irq_status_inst(.clk_i(clk_i), .nrst_i(nrst_i), .cond_i(cond_i), .mask_wdata_i(mask_wdata_i),
        .mask_we_i(mask_we_i), .status_read_done_i(rd), .status_o(status_o), .mask_o(mask_o),
        .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));
    proc_model proc_model_inst(.clk_i(clk_i), .nrst_i(nrst_i), .irq_i(int_n_oe_o), .rd_o(rd));
    task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task conclude;
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            st = 0; mk = 8'hff; pd = 0; pv = 0; oe = 0;
        end else begin
            oe = |(pd & ~mk);
            st = (st & ~(rd ? ~cond_i : 8'h00)) | (cond_i & ~pv);
            pd = (rd ? 8'h00 : pd) | (cond_i & ~pv);
            if (mask_we_i) mk = mask_wdata_i;
            pv = cond_i;
        end
    end
    always @(negedge clk_i) if ($time > 50) begin
        cmp("status", st, status_o);
        cmp("mask", mk, mask_o);
        cmp("request", {7'h0, oe}, {7'h0, int_n_oe_o});
        cmp("pin", 8'h00, {7'h0, int_n_o});
    end
    initial begin
        void'($urandom(32'h43e3_4705));
        for (int p = 0; p < 2; p++) begin
            repeat (16) @(posedge clk_i);
            #1 nrst_i = 1;
            for (int k = 0; k < 3000; k++) begin
                @(posedge clk_i);
                #1 cond_i = ($urandom % 4 == 0) ? 8'($urandom) : cond_i;
                mask_we_i = k > 12 && ($urandom % 16 == 0);
                if (mask_we_i) mask_wdata_i = 8'($urandom);
            end
            nrst_i = 0;
        end
        conclude;
    end
    initial begin
        #400000;
        err_total++;
        conclude;
    end
endmodule
